/* File: verilog/ict_defs.svh */
// Timing figures for the instruction cycle timing block
`ifndef ICT_DEFS_SVH
`define ICT_DEFS_SVH
`define ICT_CLK_PERIOD_NS 4
`define ICT_SHIFT_MIN 6
`define ICT_SHIFT_MAX_CNT 63
`define ICT_ROTX_IMM_MAX 8
`define ICT_SHIFT_IMM_TOTAL 6
`define ICT_SHIFT_IMM_HEAD 4
`define ICT_SHIFT_MEM_TOTAL 6
`define ICT_SHIFT_MEM_TAIL 2
`define ICT_BIT_IMM_TOTAL 6
`define ICT_BIT_TEST_TOTAL 4
`define ICT_BIT_MEM_TOTAL 8
`define ICT_BIT_MEM_HEAD 2
`define ICT_BIT_MEM_TAIL 2
`define ICT_BR_TAKEN 8
`define ICT_BR_BYTE_NT 4
`define ICT_BR_WORD_NT 4
`define ICT_BR_LONG_NT 6
`define ICT_DB_TRUE 4
`define ICT_DB_EXPIRE 6
`define ICT_DB_LOOP 10
`define ICT_DBL_TRUE 6
`define ICT_DBL_EXPIRE 8
`define ICT_DBL_LOOP 10
`define ICT_CHK_SAVE 3
`define ICT_CHK_OP_NOEX 18
`define ICT_CHK_OP_EX 52
`define ICT_LONG_EXTRA 2
`endif

/* File: verilog/ict_pkg.sv */
// Types for the instruction cycle timing block
package ict_pkg;
	typedef enum logic [3:0] {
		ICT_SHIFT_REG, ICT_SHIFT_IMM, ICT_SHIFT_MEM, ICT_ROTX_REG, ICT_ROTX_IMM,
		ICT_BIT_IMM, ICT_BIT_TEST_IMM, ICT_BIT_MEM, ICT_BRANCH, ICT_DEC_BRANCH, ICT_BOUNDS
	} ict_op_t;
	typedef struct packed {
		ict_op_t op;
		logic [5:0] count;
		logic [1:0] size;
		logic taken;
		logic expired;
		logic loopMode;
		logic isLong;
		logic exception;
		logic [7:0] eaClocks;
	} ict_req_t;
	typedef struct packed {
		logic [7:0] head;
		logic [7:0] tail;
		logic [7:0] total;
		logic [3:0] reads;
		logic [3:0] fetches;
		logic [3:0] writes;
	} ict_res_t;
endpackage

/* File: verilog/ict_timing.sv */
// Instruction cycle timing calculator
`include "ict_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module ict_timing (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic reqValid,
	input wire ict_pkg::ict_req_t req,
	input wire logic busMode16,
	output logic resValid,
	output ict_pkg::ict_res_t res,
	output logic modeError
);
	ict_pkg::ict_res_t next_res;
	logic next_resValid;
	logic next_modeError;
	logic busModeMeta;
	logic busModeSync;
	logic next_busModeMeta;
	logic next_busModeSync;

	// The bus-width strap is not tied to this clock, so it is retimed before use
	always_comb begin
		next_busModeMeta = busMode16;
		next_busModeSync = busModeMeta;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			// Assume the wide bus until the strap has been sampled
			busModeMeta <= 1'b1;
			busModeSync <= 1'b1;
		end else begin
			busModeMeta <= next_busModeMeta;
			busModeSync <= next_busModeSync;
		end
	end

	function automatic logic [7:0] shiftClocks(input logic [5:0] n);
		logic [7:0] q;
		logic [7:0] r;
		logic [7:0] t;
		logic [7:0] v;
		q = {4'h0, n[5:2]};
		r = {6'h00, n[1:0]};
		t = 8'h03 + q + r + {7'h00, q[0] ^ r[0] ^ 1'b1};
		v = (t < 8'h06) ? 8'h06 : t;
		shiftClocks = v;
	endfunction

	function automatic logic [7:0] maxSix(input logic [7:0] t);
		maxSix = (t < 8'h06) ? 8'h06 : t;
	endfunction

	function automatic ict_pkg::ict_res_t mk(input logic [7:0] h, input logic [7:0] tl,
		input logic [7:0] tot, input logic [3:0] r, input logic [3:0] p, input logic [3:0] w);
		ict_pkg::ict_res_t o;
		o.head = h;
		o.tail = tl;
		o.total = tot;
		o.reads = r;
		o.fetches = p;
		o.writes = w;
		mk = o;
	endfunction

	always_comb begin
		logic [7:0] n8;
		logic [7:0] ex;
		logic [3:0] busRd;
		n8 = {2'h0, req.count};
		ex = req.isLong ? 8'(`ICT_LONG_EXTRA) : 8'h00;
		busRd = req.isLong ? 4'h2 : 4'h1;
		next_res = mk(8'h00, 8'h00, 8'h00, 4'h0, 4'h0, 4'h0);
		next_resValid = reqValid;
		next_modeError = reqValid & ~busModeSync;
		case (req.op)
			ict_pkg::ICT_SHIFT_REG: begin
				next_res = mk(shiftClocks(req.count), 8'h00, shiftClocks(req.count), 4'h0, 4'h1, 4'h0);
			end
			ict_pkg::ICT_SHIFT_IMM: begin
				next_res = mk(8'(`ICT_SHIFT_IMM_HEAD), 8'h00, 8'(`ICT_SHIFT_IMM_TOTAL), 4'h0, 4'h1, 4'h0);
			end
			ict_pkg::ICT_SHIFT_MEM: begin
				next_res = mk(8'h00, 8'(`ICT_SHIFT_MEM_TAIL), 8'(`ICT_SHIFT_MEM_TOTAL), 4'h0, 4'h1, 4'h1);
			end
			ict_pkg::ICT_ROTX_REG: begin
				next_res = mk(maxSix(8'h03 + n8 + {7'h00, ~n8[0]}), 8'h00,
					maxSix(8'h03 + n8 + {7'h00, ~n8[0]}), 4'h0, 4'h1, 4'h0);
			end
			ict_pkg::ICT_ROTX_IMM: begin
				// Counts above the documented maximum are clamped rather than extrapolated
				if (n8 > 8'(`ICT_ROTX_IMM_MAX)) begin
					n8 = 8'(`ICT_ROTX_IMM_MAX);
				end
				next_res = mk(maxSix(8'h02 + n8 + {7'h00, n8[0]}), 8'h00,
					maxSix(8'h02 + n8 + {7'h00, n8[0]}), 4'h0, 4'h1, 4'h0);
			end
			ict_pkg::ICT_BIT_IMM: begin
				next_res = mk(8'h02, 8'h00, 8'(`ICT_BIT_IMM_TOTAL) + req.eaClocks, 4'h0, 4'h2, 4'h0);
			end
			ict_pkg::ICT_BIT_TEST_IMM: begin
				next_res = mk(8'h02, 8'h00, 8'(`ICT_BIT_TEST_TOTAL) + req.eaClocks, 4'h0, 4'h2, 4'h0);
			end
			ict_pkg::ICT_BIT_MEM: begin
				next_res = mk(8'(`ICT_BIT_MEM_HEAD), 8'(`ICT_BIT_MEM_TAIL), 8'(`ICT_BIT_MEM_TOTAL),
					4'h0, 4'h1, 4'h1);
			end
			ict_pkg::ICT_BRANCH: begin
				if (req.taken) begin
					next_res = mk(8'h02, 8'hFE, 8'(`ICT_BR_TAKEN), 4'h0, 4'h2, 4'h0);
				end else if (req.size == 2'h0) begin
					next_res = mk(8'h02, 8'h00, 8'(`ICT_BR_BYTE_NT), 4'h0, 4'h1, 4'h0);
				end else if (req.size == 2'h1) begin
					next_res = mk(8'h00, 8'h00, 8'(`ICT_BR_WORD_NT), 4'h0, 4'h2, 4'h0);
				end else begin
					next_res = mk(8'h00, 8'h00, 8'(`ICT_BR_LONG_NT), 4'h0, 4'h3, 4'h1);
				end
			end
			ict_pkg::ICT_DEC_BRANCH: begin
				// Taken means condition true; expired means counter reached -1
				if (!req.loopMode) begin
					if (req.taken) begin
						next_res = mk(8'h01, 8'h01, 8'(`ICT_DB_TRUE), 4'h0, 4'h2, 4'h0);
					end else if (req.expired) begin
						next_res = mk(8'h02, 8'h00, 8'(`ICT_DB_EXPIRE), 4'h0, 4'h2, 4'h0);
					end else begin
						next_res = mk(8'h06, 8'hFE, 8'(`ICT_DB_LOOP), 4'h0, 4'h2, 4'h0);
					end
				end else begin
					if (req.taken) begin
						next_res = mk(8'h04, 8'h00, 8'(`ICT_DBL_TRUE), 4'h0, 4'h1, 4'h0);
					end else if (req.expired) begin
						next_res = mk(8'h06, 8'h00, 8'(`ICT_DBL_EXPIRE), 4'h0, 4'h1, 4'h0);
					end else begin
						next_res = mk(8'h06, 8'h00, 8'(`ICT_DBL_LOOP), 4'h0, 4'h0, 4'h0);
					end
				end
			end
			ict_pkg::ICT_BOUNDS: begin
				// Plain sum of the three steps; overlap credit is left to the caller
				if (req.exception) begin
					next_res = mk(8'h01, 8'hFE + ex,
						8'(`ICT_CHK_SAVE) + req.eaClocks + 8'(`ICT_CHK_OP_EX) + ex,
						busRd + 4'h2, 4'h2, 4'h6);
				end else begin
					next_res = mk(8'h01, ex, 8'(`ICT_CHK_SAVE) + req.eaClocks + 8'(`ICT_CHK_OP_NOEX) + ex,
						busRd, 4'h1, 4'h0);
				end
			end
			default: begin
				next_resValid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			resValid <= 1'b0;
			res <= '0;
			modeError <= 1'b0;
		end else begin
			resValid <= next_resValid;
			res <= next_res;
			modeError <= next_modeError;
		end
	end

	property p_shift_floor;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_SHIFT_REG) |=> (res.total >= 8'h06 && res.total <= 8'h16);
	endproperty
	a_shift_floor: assert property (p_shift_floor) else $error("shift clocks out of range");

	property p_shift63;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_SHIFT_REG && req.count == 6'h3F) |=> res.total == 8'h16;
	endproperty
	a_shift63: assert property (p_shift63) else $error("count 63 not 22 clocks");

	property p_shift_imm;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_SHIFT_IMM) |=> (res.total == 8'h06 && res.head == 8'h04);
	endproperty
	a_shift_imm: assert property (p_shift_imm) else $error("immediate shift timing wrong");

	property p_rotx_reg;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_ROTX_REG && req.count == 6'h0A) |=> res.total == 8'h0E;
	endproperty
	a_rotx_reg: assert property (p_rotx_reg) else $error("rotate extend reg timing wrong");

	property p_rotx_imm;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_ROTX_IMM && req.count == 6'h07) |=> res.total == 8'h0A;
	endproperty
	a_rotx_imm: assert property (p_rotx_imm) else $error("rotate extend imm timing wrong");

	property p_bit_mem;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_BIT_MEM) |=> (res.total == 8'h08 && res.writes == 4'h1);
	endproperty
	a_bit_mem: assert property (p_bit_mem) else $error("memory bit op timing wrong");

	property p_branch_taken;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_BRANCH && req.taken) |=> (res.total == 8'h08 && res.fetches == 4'h2);
	endproperty
	a_branch_taken: assert property (p_branch_taken) else $error("taken branch timing wrong");

	property p_db_loop;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_DEC_BRANCH && req.loopMode && !req.taken && !req.expired)
		|=> (res.total == 8'h0A && res.fetches == 4'h0);
	endproperty
	a_db_loop: assert property (p_db_loop) else $error("loop mode branch timing wrong");

	property p_bounds;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_BOUNDS && !req.exception && !req.isLong)
		|=> res.total == $past(req.eaClocks) + 8'h15;
	endproperty
	a_bounds: assert property (p_bounds) else $error("bounds check total wrong");

	property p_mode;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && !busModeSync) |=> modeError;
	endproperty
	a_mode: assert property (p_mode) else $error("bus mode error not flagged");

	property p_mode_clear;
		@(posedge sys_clk) disable iff (reset)
		(!reqValid || busModeSync) |=> !modeError;
	endproperty
	a_mode_clear: assert property (p_mode_clear) else $error("bus mode error raised without cause");

	property p_shift_mem;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_SHIFT_MEM)
		|=> (res.total == 8'h06 && res.tail == 8'h02 && res.writes == 4'h1);
	endproperty
	a_shift_mem: assert property (p_shift_mem) else $error("memory shift timing wrong");

	property p_rotx_reg63;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_ROTX_REG && req.count == 6'h3F)
		|=> (res.total == 8'h42 && res.head == 8'h42);
	endproperty
	a_rotx_reg63: assert property (p_rotx_reg63) else $error("rotate extend count 63 timing wrong");

	property p_rotx_imm8;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_ROTX_IMM && req.count >= 6'h08)
		|=> (res.total == 8'h0A && res.head == 8'h0A);
	endproperty
	a_rotx_imm8: assert property (p_rotx_imm8) else $error("rotate extend count 8 timing wrong");

	property p_bit_imm;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_BIT_IMM)
		|=> (res.total == $past(req.eaClocks) + 8'h06 && res.fetches == 4'h2);
	endproperty
	a_bit_imm: assert property (p_bit_imm) else $error("immediate bit op timing wrong");

	property p_bit_test;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_BIT_TEST_IMM)
		|=> (res.total == $past(req.eaClocks) + 8'h04 && res.fetches == 4'h2);
	endproperty
	a_bit_test: assert property (p_bit_test) else $error("immediate bit test timing wrong");

	property p_branch_long_nt;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_BRANCH && !req.taken && req.size[1])
		|=> (res.total == 8'h06 && res.fetches == 4'h3 && res.writes == 4'h1);
	endproperty
	a_branch_long_nt: assert property (p_branch_long_nt) else $error("long branch not taken timing wrong");

	property p_db_true;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_DEC_BRANCH && !req.loopMode && req.taken)
		|=> (res.total == 8'h04 && res.head == 8'h01 && res.tail == 8'h01);
	endproperty
	a_db_true: assert property (p_db_true) else $error("decrement branch true timing wrong");

	property p_db_loop_expire;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_DEC_BRANCH && req.loopMode && !req.taken && req.expired)
		|=> (res.total == 8'h08 && res.fetches == 4'h1);
	endproperty
	a_db_loop_expire: assert property (p_db_loop_expire) else $error("loop mode expiry timing wrong");

	property p_bounds_ex;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_BOUNDS && req.exception && !req.isLong)
		|=> (res.total == $past(req.eaClocks) + 8'h37 && res.reads == 4'h3 && res.writes == 4'h6);
	endproperty
	a_bounds_ex: assert property (p_bounds_ex) else $error("bounds check exception timing wrong");

	property p_bounds_long;
		@(posedge sys_clk) disable iff (reset)
		(reqValid && req.op == ict_pkg::ICT_BOUNDS && !req.exception && req.isLong)
		|=> (res.total == $past(req.eaClocks) + 8'h17 && res.reads == 4'h2);
	endproperty
	a_bounds_long: assert property (p_bounds_long) else $error("long bounds check timing wrong");
endmodule
`default_nettype wire

/* File: test/ict_mem_model.sv */
// Memory-side model feeding the timing block its bus configuration
`timescale 1ns/100ps
`default_nettype none
module ict_mem_model (
	input wire logic narrowBus,
	output logic busMode16,
	output logic [1:0] accessClocks
);
	// Every read and write closes in two clocks, so the quoted totals hold
	assign accessClocks = 2'h2;
	// Wide port unless a scenario asks for the narrow one
	assign busMode16 = !narrowBus;
endmodule
`default_nettype wire

/* File: test/ict_timing_tb.sv */
// Self-checking bench for the instruction cycle timing block
`timescale 1ns/100ps
`default_nettype none
module ict_timing_tb;
	logic sysClk = 1'b0;
	logic reset = 1'b1;
	logic reqValid = 1'b0;
	ict_pkg::ict_req_t req = '0;
	logic narrowBus = 1'b0;
	logic busMode16, resValid, modeError;
	ict_pkg::ict_res_t res;
	int n_mismatch = 0;
	int n_tests = 0;
	int cycles = 0;
	always #2 sysClk = ~sysClk;
	ict_mem_model ict_mem_model_i (.narrowBus(narrowBus), .busMode16(busMode16), .accessClocks());
	ict_timing ict_timing_i (.sys_clk(sysClk), .reset(reset), .reqValid(reqValid), .req(req),
		.busMode16(busMode16), .resValid(resValid), .res(res), .modeError(modeError));
	task automatic conclude();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// About 340 cycles are needed; the margin covers a stuck handshake
	always @(posedge sysClk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch = n_mismatch + 1;
			conclude();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic cnt(input logic [3:0] r, input logic [3:0] p, input logic [3:0] w);
		chk({4'h0, res.reads}, {4'h0, r});
		chk({4'h0, res.fetches}, {4'h0, p});
		chk({4'h0, res.writes}, {4'h0, w});
	endtask
	// Flags are taken, expired, loop mode, long, exception
	task automatic run(input ict_pkg::ict_op_t o, input logic [5:0] n, input logic [1:0] s,
		input logic [4:0] f, input logic [7:0] ea);
		@(posedge sysClk);
		req <= {o, n, s, f, ea};
		reqValid <= 1'b1;
		@(posedge sysClk);
		reqValid <= 1'b0;
		#1;
		chk({7'h00, resValid}, 8'h01);
	endtask
	task automatic shift_reg_case();
		int q, r, e;
		for (int n = 0; n < 64; n++) begin
			q = n / 4;
			r = n % 4;
			e = 3 + q + r + (q + r + 1) % 2;
			e = e < 6 ? 6 : e;
			run(ict_pkg::ICT_SHIFT_REG, 6'(n), 2'h0, 5'h00, 8'h00);
			chk(res.total, 8'(e));
			chk(res.head, 8'(e));
		end
	endtask
	task automatic shift_fixed_case();
		run(ict_pkg::ICT_SHIFT_IMM, 6'h3F, 2'h0, 5'h00, 8'h00);
		chk(res.total, 8'h06);
		chk(res.head, 8'h04);
		cnt(4'h0, 4'h1, 4'h0);
		run(ict_pkg::ICT_SHIFT_MEM, 6'h01, 2'h1, 5'h00, 8'h00);
		chk(res.total, 8'h06);
		cnt(4'h0, 4'h1, 4'h1);
	endtask
	task automatic rotate_extend_case();
		int e;
		for (int n = 0; n < 64; n++) begin
			e = 3 + n + (n + 1) % 2;
			run(ict_pkg::ICT_ROTX_REG, 6'(n), 2'h0, 5'h00, 8'h00);
			chk(res.total, 8'(e < 6 ? 6 : e));
		end
		for (int n = 0; n < 9; n++) begin
			e = 2 + n + n % 2;
			run(ict_pkg::ICT_ROTX_IMM, 6'(n), 2'h0, 5'h00, 8'h00);
			chk(res.total, 8'(e < 6 ? 6 : e));
			chk(res.head, 8'(e < 6 ? 6 : e));
		end
	endtask
	task automatic bit_case();
		run(ict_pkg::ICT_BIT_IMM, 6'h05, 2'h0, 5'h00, 8'h03);
		chk(res.total, 8'h09);
		cnt(4'h0, 4'h2, 4'h0);
		run(ict_pkg::ICT_BIT_TEST_IMM, 6'h05, 2'h0, 5'h00, 8'h03);
		chk(res.total, 8'h07);
		run(ict_pkg::ICT_BIT_MEM, 6'h05, 2'h0, 5'h00, 8'h00);
		chk(res.total, 8'h08);
		chk(res.head, 8'h02);
		chk(res.tail, 8'h02);
		cnt(4'h0, 4'h1, 4'h1);
	endtask
	task automatic branch_case();
		run(ict_pkg::ICT_BRANCH, 6'h00, 2'h2, 5'h10, 8'h00);
		chk(res.total, 8'h08);
		cnt(4'h0, 4'h2, 4'h0);
		run(ict_pkg::ICT_BRANCH, 6'h00, 2'h0, 5'h00, 8'h00);
		chk(res.total, 8'h04);
		cnt(4'h0, 4'h1, 4'h0);
		run(ict_pkg::ICT_BRANCH, 6'h00, 2'h1, 5'h00, 8'h00);
		chk(res.total, 8'h04);
		cnt(4'h0, 4'h2, 4'h0);
		run(ict_pkg::ICT_BRANCH, 6'h00, 2'h3, 5'h00, 8'h00);
		chk(res.total, 8'h06);
		cnt(4'h0, 4'h3, 4'h1);
	endtask
	task automatic dec_branch_case();
		for (int lm = 0; lm < 2; lm++) begin
			run(ict_pkg::ICT_DEC_BRANCH, 6'h00, 2'h1, {2'b10, lm[0], 2'b00}, 8'h00);
			chk(res.total, 8'(4 + 2 * lm));
			run(ict_pkg::ICT_DEC_BRANCH, 6'h00, 2'h1, {2'b01, lm[0], 2'b00}, 8'h00);
			chk(res.total, 8'(6 + 2 * lm));
			run(ict_pkg::ICT_DEC_BRANCH, 6'h00, 2'h1, {2'b00, lm[0], 2'b00}, 8'h00);
			chk(res.total, 8'h0A);
			chk({4'h0, res.fetches}, 8'(2 - 2 * lm));
		end
	endtask
	task automatic bounds_case();
		run(ict_pkg::ICT_BOUNDS, 6'h00, 2'h1, 5'h00, 8'h05);
		chk(res.total, 8'h1A);
		cnt(4'h1, 4'h1, 4'h0);
		run(ict_pkg::ICT_BOUNDS, 6'h00, 2'h1, 5'h01, 8'h05);
		chk(res.total, 8'h3C);
		cnt(4'h3, 4'h2, 4'h6);
		run(ict_pkg::ICT_BOUNDS, 6'h00, 2'h2, 5'h02, 8'h05);
		chk(res.total, 8'h1C);
		chk({4'h0, res.reads}, 8'h02);
	endtask
	task automatic mode_case();
		@(posedge sysClk);
		narrowBus <= 1'b1;
		// The block retimes the strap through two flops before using it
		repeat (2) @(posedge sysClk);
		run(ict_pkg::ICT_SHIFT_IMM, 6'h01, 2'h0, 5'h00, 8'h00);
		chk({7'h00, modeError}, 8'h01);
		@(posedge sysClk);
		narrowBus <= 1'b0;
		repeat (2) @(posedge sysClk);
		run(ict_pkg::ICT_SHIFT_IMM, 6'h01, 2'h0, 5'h00, 8'h00);
		chk({7'h00, modeError}, 8'h00);
	endtask
	task automatic refuse_case();
		@(posedge sysClk);
		req.op <= ict_pkg::ict_op_t'(4'hF);
		reqValid <= 1'b1;
		@(posedge sysClk);
		reqValid <= 1'b0;
		#1;
		chk({7'h00, resValid}, 8'h00);
		chk(res.total, 8'h00);
	endtask
	initial begin
		repeat (20) @(posedge sysClk);
		reset <= 1'b0;
		shift_reg_case();
		shift_fixed_case();
		rotate_extend_case();
		bit_case();
		branch_case();
		dec_branch_case();
		bounds_case();
		mode_case();
		refuse_case();
		conclude();
	end
endmodule
`default_nettype wire
